// ---- ofrs_consts.vh ----
`ifndef OFRS_CONSTS_VH
`define OFRS_CONSTS_VH

// command codes, used as register offsets
`define OFRS_ADDR_OPERATION 8'h01
`define OFRS_ADDR_CLEAR     8'h03
`define OFRS_ADDR_STATUS    8'h79
`define OFRS_ADDR_PG_ON     8'h5e
`define OFRS_ADDR_PG_OFF    8'h5f
`define OFRS_ADDR_TON_DLY   8'h60
`define OFRS_ADDR_TURN_ON_RAMP_TIME  8'h61
`define OFRS_ADDR_TON_MAX   8'h62
`define OFRS_ADDR_TMO_RESP  8'h63
`define OFRS_ADDR_DLY_UNIT  8'hd2

// operation register field
`define OFRS_OP_ON_BIT      7

// fault response byte fields
`define OFRS_RESP_MSB       7
`define OFRS_RESP_LSB       6
`define OFRS_RETRY_MSB      5
`define OFRS_RETRY_LSB      3
`define OFRS_DLY_MSB        2
`define OFRS_DLY_LSB        0

// response and retry codes
`define OFRS_RESP_IGNORE    2'h0
`define OFRS_RESP_OPERATE   2'h1
`define OFRS_RESP_LATCH     2'h3
`define OFRS_RETRY_NONE     3'h0
`define OFRS_RETRY_FOREVER  3'h7

// status register fields
`define OFRS_ST_FLT_BIT     0
`define OFRS_ST_PG_BIT      1
`define OFRS_ST_LATCH_BIT   2
`define OFRS_ST_CNT_LSB     4

// linear format fields
`define OFRS_LIN_EXP_MSB    15
`define OFRS_LIN_EXP_LSB    11
`define OFRS_LIN_MAN_MSB    10

// reset values
`define OFRS_RST_OPERATION  8'h80
`define OFRS_RST_PG_ON      16'h0000
`define OFRS_RST_PG_OFF     16'h0000
`define OFRS_RST_TON_DLY    16'h0000
`define OFRS_RST_TURN_ON_RAMP_TIME   16'h0000
`define OFRS_RST_TON_MAX    16'h0000
`define OFRS_RST_TMO_RESP   8'h80
`define OFRS_RST_DLY_UNIT   16'h0001

// timing: one millisecond and the clock period, in ns
`define OFRS_MS_NS          1000000
`define OFRS_CLK_NS         8

`endif

// ---- ofrs_retry_startup.v ----
// Summary of operation
// - retry codes 011..110 give three to six restart attempts
// - attempts used up: output stays off until the fault is cleared
// - retry code 111 retries forever until off command or other stop
// - delay field n selects 2 to the power n delay units
// - delay interval times operate-then-respond and restart spacing
// - delay unit length comes from its own register
// - power good asserts when output reaches the assert level
// - below negate level: status bit set, pin negated if enabled
// - after enable wait turn-on delay before the ramp starts
// - after the delay ramp the output over the ramp time
// - startup timeout fault if undervoltage limit not reached in time
// - timeout limit zero means no limit
// - retry codes 000, 001, 010 give zero, one, two attempts
// - response field: ignore, operate then retry, disable, latch off
// - fault cleared by bit clear, clear command, off then on, power
`timescale 1ns/1ns
`default_nettype none
`include "ofrs_consts.vh"

module ofrs_retry_startup #(
  parameter [23:0] P_MS_CYCLES = `OFRS_MS_NS / `OFRS_CLK_NS
) (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_ctrl_on,
  input  wire        i_pg_pin_en,
  input  wire [15:0] i_vout,
  input  wire [15:0] i_uv_limit,
  input  wire        i_fault_det,
  output reg  [15:0] o_rdata,
  output reg         o_out_en,
  output reg         o_ramp,
  output reg         o_output_good_pin,
  output reg         o_fault_off
);

  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_DLY   = 3'h1;
  localparam [2:0] ST_RISE  = 3'h2;
  localparam [2:0] ST_ON    = 3'h3;
  localparam [2:0] ST_FOP   = 3'h4;
  localparam [2:0] ST_WAIT  = 3'h5;
  localparam [2:0] ST_LATCH = 3'h6;

  // linear value to whole ms, negative and overflow handled
  function [23:0] lin_ms;
    input [15:0] v;
    reg   [4:0]  e;
    reg   [41:0] w;
    begin
      e = v[`OFRS_LIN_EXP_MSB:`OFRS_LIN_EXP_LSB];
      w = {31'h0, v[`OFRS_LIN_MAN_MSB:0]};
      if (v[`OFRS_LIN_MAN_MSB]) begin
        w = 42'h0;
      end else if (e[4]) begin
        w = w >> (~e + 5'h1);
      end else begin
        w = w << e;
      end
      lin_ms = (|w[41:24]) ? 24'hffffff : w[23:0];
    end
  endfunction

  // delay field as exponent times the unit length
  function [23:0] dly_ms;
    input [2:0]  code;
    input [15:0] unit;
    begin
      dly_ms = {8'h0, unit} << code;
    end
  endfunction

  reg        rst_meta;
  reg        rst_n;
  reg        ctrl_meta;
  reg        ctrl_s;
  reg [7:0]  op_reg;
  reg [15:0] pg_on;
  reg [15:0] pg_off;
  reg [15:0] ton_dly;
  reg [15:0] turn_on_ramp_time;
  reg [15:0] ton_max;
  reg [7:0]  tmo_resp;
  reg [15:0] dly_unit;
  reg [2:0]  state;
  reg [23:0] tmr;
  reg [23:0] pre;
  reg [23:0] tmax_cnt;
  reg [2:0]  cnt;
  reg        flt;
  reg        pg_good;
  reg [2:0]  next_state;
  reg [23:0] next_tmr;
  reg [2:0]  next_cnt;
  reg        next_pg;
  reg        do_retry;
  reg [15:0] rd_val;

  // reset release through two flops
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  wire       wr_clear = i_wr_en && (i_addr == `OFRS_ADDR_CLEAR);
  wire       wr_stat  = i_wr_en && (i_addr == `OFRS_ADDR_STATUS);
  wire       clr      = wr_clear || (wr_stat && i_wdata[`OFRS_ST_FLT_BIT]);
  wire       on_cmd   = ctrl_s && op_reg[`OFRS_OP_ON_BIT];
  wire [1:0] rsp      = tmo_resp[`OFRS_RESP_MSB:`OFRS_RESP_LSB];
  wire [2:0] retries  = tmo_resp[`OFRS_RETRY_MSB:`OFRS_RETRY_LSB];
  wire [2:0] dcode    = tmo_resp[`OFRS_DLY_MSB:`OFRS_DLY_LSB];
  wire       tick     = (pre == P_MS_CYCLES - 24'h1);
  wire       starting = (state == ST_DLY) || (state == ST_RISE);
  wire       running  = starting || (state == ST_ON);
  wire [23:0] tmax_lim = lin_ms(ton_max);
  wire       below_uv = (i_vout < i_uv_limit);
  // timeout only with a nonzero limit
  wire       tmo = starting && (tmax_lim != 24'h0) &&
                   (tmax_cnt >= tmax_lim) && below_uv;
  wire       flt_event = running && (tmo || i_fault_det) &&
                         (rsp != `OFRS_RESP_IGNORE);
  // no attempts left, or latch-off response
  wire       give_up = (rsp == `OFRS_RESP_LATCH) ||
                       (retries == `OFRS_RETRY_NONE) ||
                       ((retries != `OFRS_RETRY_FOREVER) &&
                        (cnt >= retries));

  // sequencer next state
  always @* begin
    next_state = state;
    next_tmr   = (tick && (tmr != 24'h0)) ? tmr - 24'h1 : tmr;
    next_cnt   = cnt;
    do_retry   = 1'b0;
    case (state)
      ST_OFF: begin
        if (on_cmd) begin
          next_state = ST_DLY;
          next_tmr   = lin_ms(ton_dly);
        end
      end
      ST_DLY: begin
        if (tmr == 24'h0) begin
          next_state = ST_RISE;
          next_tmr   = lin_ms(turn_on_ramp_time);
        end
      end
      ST_RISE: begin
        if ((tmr == 24'h0) && !below_uv) begin
          next_state = ST_ON;
          next_cnt   = 3'h0;
        end
      end
      ST_ON: next_state = ST_ON; // faults handled below
      ST_FOP: begin
        if (tmr == 24'h0) begin
          if (i_fault_det || below_uv) begin
            do_retry = 1'b1;
          end else begin
            next_state = ST_ON;
          end
        end
      end
      ST_WAIT: begin
        if (tmr == 24'h0) begin
          next_state = ST_DLY;
          next_tmr   = lin_ms(ton_dly);
        end
      end
      ST_LATCH: begin
        if (clr) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // fault response overrides sequencing
    if (flt_event) begin
      if (rsp == `OFRS_RESP_OPERATE) begin
        next_state = ST_FOP;
        next_tmr   = dly_ms(dcode, dly_unit);
      end else begin
        do_retry = 1'b1;
      end
    end
    if (do_retry) begin
      if (give_up) begin
        next_state = ST_LATCH;
      end else begin
        next_state = ST_WAIT;
        next_cnt   = cnt + 3'h1;
        next_tmr   = dly_ms(dcode, dly_unit);
      end
    end
    // off command stops everything, incl. endless retry
    if (!on_cmd) begin
      next_state = ST_OFF;
      next_cnt   = 3'h0;
    end
    if (clr) begin
      next_cnt = 3'h0;
    end
  end

  // power good hysteresis on the two levels
  always @* begin
    next_pg = pg_good;
    if ((next_state != ST_RISE) && (next_state != ST_ON) &&
        (next_state != ST_FOP)) begin
      next_pg = 1'b0;
    end else if (i_vout >= pg_on) begin
      next_pg = 1'b1;
    end else if (i_vout < pg_off) begin
      next_pg = 1'b0;
    end
  end

  // register read decode
  always @* begin
    rd_val = 16'h0;
    if (i_addr == `OFRS_ADDR_OPERATION) begin
      rd_val = {8'h0, op_reg};
    end else if (i_addr == `OFRS_ADDR_PG_ON) begin
      rd_val = pg_on;
    end else if (i_addr == `OFRS_ADDR_PG_OFF) begin
      rd_val = pg_off;
    end else if (i_addr == `OFRS_ADDR_TON_DLY) begin
      rd_val = ton_dly;
    end else if (i_addr == `OFRS_ADDR_TURN_ON_RAMP_TIME) begin
      rd_val = turn_on_ramp_time;
    end else if (i_addr == `OFRS_ADDR_TON_MAX) begin
      rd_val = ton_max;
    end else if (i_addr == `OFRS_ADDR_TMO_RESP) begin
      rd_val = {8'h0, tmo_resp};
    end else if (i_addr == `OFRS_ADDR_DLY_UNIT) begin
      rd_val = dly_unit;
    end else if (i_addr == `OFRS_ADDR_STATUS) begin
      rd_val = 16'h0;
      rd_val[`OFRS_ST_FLT_BIT]   = flt;
      rd_val[`OFRS_ST_PG_BIT]    = ~pg_good;
      rd_val[`OFRS_ST_LATCH_BIT] = (state == ST_LATCH);
      rd_val[`OFRS_ST_CNT_LSB+2:`OFRS_ST_CNT_LSB] = cnt;
    end
  end

  // config registers
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg   <= `OFRS_RST_OPERATION;
      pg_on    <= `OFRS_RST_PG_ON;
      pg_off   <= `OFRS_RST_PG_OFF;
      ton_dly  <= `OFRS_RST_TON_DLY;
      turn_on_ramp_time <= `OFRS_RST_TURN_ON_RAMP_TIME;
      ton_max  <= `OFRS_RST_TON_MAX;
      tmo_resp <= `OFRS_RST_TMO_RESP;
      dly_unit <= `OFRS_RST_DLY_UNIT;
      o_rdata  <= 16'h0;
    end else if (i_ce) begin
      if (i_rd_en) begin
        o_rdata <= rd_val;
      end
      if (i_wr_en) begin
        if (i_addr == `OFRS_ADDR_OPERATION) begin
          op_reg <= i_wdata[7:0];
        end else if (i_addr == `OFRS_ADDR_PG_ON) begin
          pg_on <= i_wdata;
        end else if (i_addr == `OFRS_ADDR_PG_OFF) begin
          pg_off <= i_wdata;
        end else if (i_addr == `OFRS_ADDR_TON_DLY) begin
          ton_dly <= i_wdata;
        end else if (i_addr == `OFRS_ADDR_TURN_ON_RAMP_TIME) begin
          turn_on_ramp_time <= i_wdata;
        end else if (i_addr == `OFRS_ADDR_TON_MAX) begin
          ton_max <= i_wdata;
        end else if (i_addr == `OFRS_ADDR_TMO_RESP) begin
          tmo_resp <= i_wdata[7:0];
        end else if (i_addr == `OFRS_ADDR_DLY_UNIT) begin
          dly_unit <= i_wdata;
        end
      end
    end
  end

  // sequencer, timers and outputs
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_meta         <= 1'b0;
      ctrl_s            <= 1'b0;
      state             <= ST_OFF;
      tmr               <= 24'h0;
      pre               <= 24'h0;
      tmax_cnt          <= 24'h0;
      cnt               <= 3'h0;
      flt               <= 1'b0;
      pg_good           <= 1'b0;
      o_out_en          <= 1'b0;
      o_ramp            <= 1'b0;
      o_output_good_pin <= 1'b0;
      o_fault_off       <= 1'b0;
    end else if (i_ce) begin
      ctrl_meta <= i_ctrl_on;
      ctrl_s    <= ctrl_meta;
      state     <= next_state;
      tmr       <= next_tmr;
      cnt       <= next_cnt;
      pg_good   <= next_pg;
      // ms prescaler restarts with every new interval
      if (tick || (next_state != state)) begin
        pre <= 24'h0;
      end else begin
        pre <= pre + 24'h1;
      end
      // time since enable, for the turn-on limit
      if (!starting) begin
        tmax_cnt <= 24'h0;
      end else if (tick && (tmax_cnt != 24'hffffff)) begin
        tmax_cnt <= tmax_cnt + 24'h1;
      end
      // sticky fault, set wins over clear
      if (flt_event) begin
        flt <= 1'b1;
      end else if (clr || !on_cmd) begin
        flt <= 1'b0;
      end
      o_out_en <= (next_state == ST_RISE) || (next_state == ST_ON) ||
                  (next_state == ST_FOP);
      o_ramp   <= (next_state == ST_RISE);
      o_output_good_pin <= next_pg && i_pg_pin_en;
      o_fault_off <= (next_state == ST_LATCH);
    end
  end

endmodule
`default_nettype wire

// ---- ofrs_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module ofrs_props (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire logic        i_wr_en,
  input wire logic        i_ctrl_on,
  input wire logic [15:0] i_vout,
  input wire logic [15:0] i_uv_limit,
  input wire logic        o_out_en,
  input wire logic        o_ramp,
  input wire logic        o_output_good_pin,
  input wire logic        o_fault_off
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // sequencing and latch-off relations
  chk_ramp_has_en: assert property (o_ramp |-> o_out_en)
    else $error("ramp seen with output disabled");
  chk_ramp_entry: assert property ($rose(o_out_en) |-> o_ramp)
    else $error("enable rose without ramp");
  chk_ramp_exit: assert property ($fell(o_ramp) && o_out_en
    |-> $past(i_vout) >= $past(i_uv_limit))
    else $error("ramp left below undervoltage limit");
  chk_latch_blocks: assert property (o_fault_off |-> !o_out_en)
    else $error("output on while latched off");
  chk_latch_holds: assert property (o_fault_off && i_ctrl_on
    && $past(i_ctrl_on) && $past(i_ctrl_on, 2) && !i_wr_en
    && !$past(i_wr_en) && !$past(i_wr_en, 2) |=> o_fault_off)
    else $error("latched off cleared without cause");
  chk_off_stops: assert property ((!i_ctrl_on && i_ce) [*5]
    |-> !o_out_en && !o_fault_off)
    else $error("output not stopped by off command");
  chk_on_needs_ctrl: assert property ($rose(o_out_en)
    |-> $past(i_ctrl_on, 2) && $past(i_ctrl_on, 3))
    else $error("enable rose without on command");
  chk_pin_needs_en: assert property (o_output_good_pin |-> o_out_en)
    else $error("power good with output disabled");
endmodule
bind ofrs_retry_startup ofrs_props ofrs_props_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_wr_en(i_wr_en),
  .i_ctrl_on(i_ctrl_on), .i_vout(i_vout), .i_uv_limit(i_uv_limit),
  .o_out_en(o_out_en), .o_ramp(o_ramp), .o_fault_off(o_fault_off),
  .o_output_good_pin(o_output_good_pin));
`default_nettype wire

// ---- ofrs_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ofrs_host_model (
  input  wire logic        i_clk,
  output var  logic        o_wr_en,
  output var  logic        o_rd_en,
  output var  logic [7:0]  o_addr,
  output var  logic [15:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  // one-cycle write; released lines show inverted data
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // one-cycle read strobe
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ---- ofrs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 0, nrst = 0, ce = 1, ctrl = 0, pgen = 1, fdet = 0;
  logic [15:0] vout = 0, uv = 16'h0100, rdata;
  logic        oen, ramp, pin, foff, rd_d = 0;
  wire         wr, rd;
  wire  [7:0]  addr;
  wire  [15:0] wd;
  logic [15:0] expq[$];
  int          num_errors = 0, total_checks = 0, cyc = 0, n, k, t, m;
  always #4 clk = ~clk;
  ofrs_host_model ofrs_host_model_inst (.i_clk(clk), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(addr), .o_wdata(wd));
  ofrs_retry_startup #(.P_MS_CYCLES(24'd4)) ofrs_retry_startup_inst (
    .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(addr), .i_wdata(wd), .i_ctrl_on(ctrl), .i_pg_pin_en(pgen),
    .i_vout(vout), .i_uv_limit(uv), .i_fault_det(fdet), .o_rdata(rdata),
    .o_out_en(oen), .o_ramp(ramp), .o_output_good_pin(pin),
    .o_fault_off(foff));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task w(input logic [7:0] a, input logic [15:0] d);
    ofrs_host_model_inst.wr(a, d);
  endtask
  task r(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    ofrs_host_model_inst.rd(a);
  endtask
  // wait for an output level, counting cycles in t
  task wt(input int s, input logic v);
    t = 0;
    while ((s == 0 ? oen : s == 1 ? ramp : foff) !== v && t < 700) begin
      @(posedge clk);
      t++;
    end
    chk("wait", t < 700, 1);
  endtask
  // read data checked one cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) chk("rdata", rdata, expq.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      num_errors++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(62));
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    r(8'h01, 16'h0080);
    r(8'h63, 16'h0080);
    r(8'hd2, 16'h0001);
    r(8'h10, 16'h0000);
    for (k = 8'h5e; k <= 8'h62; k++) begin
      n = $urandom;
      w(k[7:0], n[15:0]);
      r(k[7:0], n[15:0]);
    end
    w(8'h60, 16'h0003);
    w(8'h61, 16'h0002);
    w(8'h62, 16'h0000);
    w(8'h5e, 16'h0200);
    w(8'h5f, 16'h0180);
    ctrl <= 1;
    wt(0, 1);
    // 12 cycles of delay plus sync, state entry and sampling lag
    chk("turn_on_delay_time", t >= 16 && t <= 18, 1);
    chk("ramp", ramp, 1);
    repeat (40) @(posedge clk);
    chk("no_limit", {ramp, foff}, 2'b10);
    vout <= 16'h0200 + 16'($urandom % 256);
    wt(1, 0);
    repeat (4) @(posedge clk);
    chk("pg_on", pin, 1);
    pgen <= 0;
    repeat (2) @(posedge clk);
    chk("pin_en", pin, 0);
    pgen <= 1;
    r(8'h79, 16'h0000);
    vout <= 16'h0150;
    repeat (4) @(posedge clk);
    chk("pg_off", pin, 0);
    r(8'h79, 16'h0002);
    ce <= 0;
    fdet <= 1;
    repeat (6) @(posedge clk);
    chk("frozen", oen, 1);
    fdet <= 0;
    ce <= 1;
    ctrl <= 0;
    w(8'h60, 16'h0000);
    repeat (6) @(posedge clk);
    for (n = 0; n < 8; n++) begin
      w(8'h63, {8'h00, 2'b10, n[2:0], n[2:0]});
      ctrl <= 1;
      wt(0, 1);
      wt(1, 0);
      // fault shows up each time the output comes back up
      fdet <= 1;
      k = 0;
      while (k < 8 && foff !== 1) begin
        wt(0, 0);
        fdet <= 0;
        t = 0;
        while (oen !== 1 && foff !== 1 && t < 700) begin
          @(posedge clk);
          t++;
        end
        if (oen === 1) begin
          k++;
          chk("gap", t >= (4 << n) && t <= (4 << n) + 6, 1);
          fdet <= (k < 8);
        end
      end
      chk("tries", k, n == 7 ? 8 : n);
      if (n < 7) begin
        chk("latched", foff, 1);
        r(8'h79, {9'h000, n[2:0], 4'h7});
        if (n[0]) w(8'h03, 16'h0000);
        else w(8'h79, 16'h0001);
        wt(2, 0);
        r(8'h79, 16'h0002);
      end
      ctrl <= 0;
      repeat (6) @(posedge clk);
      chk("off", oen, 0);
    end
    for (m = 0; m < 4; m++) if (m != 2) begin
      w(8'h63, {8'h00, m[1:0], 6'b001001});
      ctrl <= 1;
      wt(0, 1);
      wt(1, 0);
      fdet <= 1;
      repeat (4) @(posedge clk);
      chk("resp_a", oen, m != 3);
      repeat (9) @(posedge clk);
      chk("resp_b", {oen, foff}, m == 0 ? 2'b10 : m == 1 ? 2'b00 : 2'b01);
      fdet <= 0;
      ctrl <= 0;
      repeat (6) @(posedge clk);
    end
    w(8'h62, 16'h0002);
    w(8'h63, 16'h00c0);
    vout <= 16'h0000;
    ctrl <= 1;
    wt(2, 1);
    chk("timeout", t >= 8 && t <= 14, 1);
    ctrl <= 0;
    repeat (6) @(posedge clk);
    finish_test;
  end
endmodule
`default_nettype wire
